// File: pkg/lpcap_pkg.sv
package lpcap_pkg;

	// ***********************************
	// region map of the sideband space
	// ***********************************
	localparam logic [7:0] CAP_BASE = 8'h00;
	localparam logic [7:0] CAP_LAST = 8'h0f;
	localparam logic [7:0] INT_BASE = 8'h20;
	localparam logic [7:0] INT_LAST = 8'h2f;
	localparam logic [7:0] STAT_BASE = 8'h30;
	localparam logic [7:0] STAT_LAST = 8'h3f;
	localparam logic [7:0] SCR_BASE = 8'h40;
	localparam logic [7:0] SCR_LAST = 8'h7f;

	// ***********************************
	// capability offsets
	// ***********************************
	localparam logic [3:0] OFS_CONNECTION_STATE = 4'h0;
	localparam logic [3:0] OFS_SPEC_VERSION_LEVEL = 4'h1;
	localparam logic [3:0] OFS_DEVICE_CATEGORY = 4'h2;
	localparam logic [3:0] OFS_MAKER_ID_HIGH = 4'h3;
	localparam logic [3:0] OFS_MAKER_ID_LOW = 4'h4;
	localparam logic [3:0] OFS_VIDEO_LINK_MODES = 4'h5;
	localparam logic [3:0] OFS_AUDIO_LINK_MODES = 4'h6;
	localparam logic [3:0] OFS_VIDEO_CONTENT_TYPES = 4'h7;
	localparam logic [3:0] OFS_LOGICAL_FUNCTION_MAP = 4'h8;
	localparam logic [3:0] OFS_LINK_CLOCK_LIMIT = 4'h9;
	localparam logic [3:0] OFS_OPTIONAL_FEATURE_FLAGS = 4'ha;
	localparam logic [3:0] OFS_PRODUCT_ID_HIGH = 4'hb;
	localparam logic [3:0] OFS_PRODUCT_ID_LOW = 4'hc;
	localparam logic [3:0] OFS_SCRATCHPAD_COUNT = 4'hd;
	localparam logic [3:0] OFS_INTERRUPT_STATUS_COUNTS = 4'he;

	// ***********************************
	// field positions and codes
	// ***********************************
	localparam int CAT_POWER_BIT = 4;
	localparam int CAT_PLIM_LSB = 5;
	localparam logic [3:0] DEV_TYPE_SINK = 4'h1;
	localparam logic [3:0] DEV_TYPE_SOURCE = 4'h2;
	localparam logic [3:0] DEV_TYPE_DONGLE = 4'h3;
	localparam logic [1:0] PLIM_500MA = 2'h0;
	localparam logic [1:0] PLIM_900MA = 2'h1;
	localparam logic [1:0] PLIM_1500MA = 2'h2;
	localparam logic [1:0] PLIM_DONGLE_MIN = 2'h3;
	localparam logic [15:0] MAKER_ID_NONE = 16'h0000;
	localparam logic [15:0] MAKER_ID_FIRST_VALID = 16'h0080;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ***********************************
	// sideband command and answer
	// ***********************************
	typedef enum logic [1:0] {
		LPCAP_OP_READ_CAP = 2'h0,
		LPCAP_OP_SET_INT = 2'h1,
		LPCAP_OP_WRITE_STAT = 2'h2,
		LPCAP_OP_WRITE_BURST = 2'h3
	} lpcap_op_e;

	typedef struct packed {
		lpcap_op_e op;
		logic [7:0] offset;
		logic [7:0] data;
	} lpcap_cmd_s;

	typedef struct packed {
		logic [7:0] data;
		logic error;
	} lpcap_rsp_s;

	typedef struct packed {
		logic [3:0] dev_type;
		logic power;
		logic [1:0] plim;
	} lpcap_cat_s;

endpackage

// File: rtl/lpcap_regs.sv
`timescale 1ns/1ps
// How it works
// RULE_01: capability-read returns a byte for every offset 0x00 through 0x0F.
// RULE_02: peer commands never alter any capability byte.
// RULE_03: interrupt region 0x20-0x2F, peer may only set bits there.
// RULE_04: status region 0x30-0x3F is written by peer write-status.
// RULE_05: scratchpad 0x40-0x7F, filled by burst writes, sixteen to 64 bytes.
// RULE_06: offsets outside all four regions are reserved and do nothing.
// RULE_07: byte 0x0D holds scratchpad count, 0x0E interrupt and status counts.
// RULE_08: version byte is major nibble over minor nibble, 2.0 reads 0x20.
// RULE_09: device type field never zero, sink 1, source 2, dongle 3.
// RULE_10: category bit 4 set only when bus power can be supplied.
// RULE_11: category bits 6:5 give the minimum delivered power code.
// RULE_12: unpowered device clears power bit; limit bits then meaningless.
// RULE_13: category byte follows live inputs and may change at run time.
// RULE_14: maker id high byte at 0x03, low at 0x04, zero means none.
// RULE_15: maker ids 1 through 127 are never reported.
// RULE_16: peer uses scratchpad freely when maker id is zero.
// RULE_17: video mode byte bits 0..3 flag the four pixel link modes.
// RULE_18: fields needed for the device type carry accurate values.
// RULE_19: connection state byte exists with all bits reserved.
// RULE_20: capability changes are signalled through the interrupt region; a category byte change sets bit 0 of byte 0x20; peer set-interrupt ORs in its data.
// RULE_21: reserved bits and byte 0x0F read back as zero.
module lpcap_regs
	import lpcap_pkg::*;
#(
	parameter int INT_COUNT = 4,
	parameter int STAT_COUNT = 4,
	parameter int SCR_COUNT = 16,
	parameter logic [3:0] VERSION_MAJOR = 4'h2,
	parameter logic [3:0] VERSION_MINOR = 4'h0,
	parameter logic [15:0] MAKER_ID = 16'h0000, // arbitrary neutral value
	parameter logic [15:0] PRODUCT_ID = 16'h0000 // arbitrary neutral value
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire lpcap_cmd_s cmd,
	output lpcap_rsp_s rsp,
	output logic rsp_valid,
	input wire lpcap_cat_s category,
	input wire logic [7:0] video_link_modes,
	input wire logic [7:0] audio_link_modes,
	input wire logic [7:0] video_content_types,
	input wire logic [7:0] logical_function_map,
	input wire logic [7:0] link_clock_limit,
	input wire logic [7:0] optional_feature_flags,
	input wire logic [4:0] int_bit_sel,
	input wire logic int_bit_clear,
	output logic [8*INT_COUNT-1:0] int_regs,
	output logic [8*STAT_COUNT-1:0] stat_regs,
	output logic [8*SCR_COUNT-1:0] scr_regs,
	output logic cap_changed
);

	// ***********************************
	// capability image
	// ***********************************
	logic [7:0] cap_byte;
	logic [7:0] cat_byte;
	logic [15:0] maker_id_out;
	logic [7:0] cat_prev_q;
	logic [7:0] cat_prev_d;

	// category assembly, power limit masked when unpowered
	always_comb begin
		cat_byte = RESET_BYTE;
		cat_byte[3:0] = category.dev_type; // [RULE_09]
		if (category.dev_type == 4'h0)
			cat_byte[3:0] = DEV_TYPE_SINK; // never report zero [RULE_09]
		cat_byte[CAT_POWER_BIT] = category.power; // [RULE_10] [RULE_13]
		if (category.power)
			cat_byte[CAT_PLIM_LSB+:2] = category.plim; // [RULE_11]
		else
			cat_byte[CAT_PLIM_LSB+:2] = PLIM_500MA; // [RULE_12]
	end

	// reserved maker ids collapse to none
	assign maker_id_out = (MAKER_ID != MAKER_ID_NONE && MAKER_ID < MAKER_ID_FIRST_VALID)
		? MAKER_ID_NONE : MAKER_ID; // [RULE_15] [RULE_14]

	// capability read mux
	always_comb begin
		cap_byte = RESET_BYTE; // covers 0x00 and 0x0f [RULE_19] [RULE_21]
		unique case (cmd.offset[3:0])
			OFS_SPEC_VERSION_LEVEL: cap_byte = {VERSION_MAJOR, VERSION_MINOR}; // [RULE_08]
			OFS_DEVICE_CATEGORY: cap_byte = cat_byte;
			OFS_MAKER_ID_HIGH: cap_byte = maker_id_out[15:8]; // [RULE_14]
			OFS_MAKER_ID_LOW: cap_byte = maker_id_out[7:0];
			OFS_VIDEO_LINK_MODES: cap_byte = {4'h0, video_link_modes[3:0]}; // [RULE_17]
			OFS_AUDIO_LINK_MODES: cap_byte = {6'h00, audio_link_modes[1:0]}; // [RULE_18]
			OFS_VIDEO_CONTENT_TYPES: cap_byte = {video_content_types[7], 3'h0,
				video_content_types[3:0]}; // [RULE_18]
			OFS_LOGICAL_FUNCTION_MAP: cap_byte = logical_function_map;
			OFS_LINK_CLOCK_LIMIT: cap_byte = link_clock_limit;
			OFS_OPTIONAL_FEATURE_FLAGS: cap_byte = optional_feature_flags;
			OFS_PRODUCT_ID_HIGH: cap_byte = PRODUCT_ID[15:8];
			OFS_PRODUCT_ID_LOW: cap_byte = PRODUCT_ID[7:0];
			OFS_SCRATCHPAD_COUNT: cap_byte = 8'(SCR_COUNT); // [RULE_07]
			OFS_INTERRUPT_STATUS_COUNTS: cap_byte = {4'(INT_COUNT), 4'(STAT_COUNT)}; // [RULE_07]
			default: cap_byte = RESET_BYTE;
		endcase
	end

	// ***********************************
	// command decode
	// ***********************************
	logic in_cap;
	logic in_int;
	logic in_stat;
	logic in_scr;
	logic [7:0] rel_int;
	logic [7:0] rel_stat;
	logic [7:0] rel_scr;

	// region hit tests, writable space limited to implemented bytes
	always_comb begin
		rel_int = cmd.offset - INT_BASE;
		rel_stat = cmd.offset - STAT_BASE;
		rel_scr = cmd.offset - SCR_BASE;
		in_cap = cmd.offset <= CAP_LAST; // [RULE_01]
		in_int = cmd.offset >= INT_BASE && cmd.offset <= INT_LAST
			&& rel_int < 8'(INT_COUNT); // [RULE_03]
		in_stat = cmd.offset >= STAT_BASE && cmd.offset <= STAT_LAST
			&& rel_stat < 8'(STAT_COUNT); // [RULE_04]
		in_scr = cmd.offset >= SCR_BASE && cmd.offset <= SCR_LAST
			&& rel_scr < 8'(SCR_COUNT); // [RULE_05]
	end

	// ***********************************
	// writable regions
	// ***********************************
	logic [8*INT_COUNT-1:0] int_q;
	logic [8*INT_COUNT-1:0] int_d;
	logic [8*STAT_COUNT-1:0] stat_q;
	logic [8*STAT_COUNT-1:0] stat_d;
	logic [8*SCR_COUNT-1:0] scr_q;
	logic [8*SCR_COUNT-1:0] scr_d;

	// next values for region bytes
	genvar gi;
	generate
		for (gi = 0; gi < INT_COUNT; gi++) begin : g_int
			logic [7:0] nb;
			// one private byte per process, so no two processes share a variable
			always_comb begin
				nb = int_q[8*gi+:8];
				if (int_bit_clear && int_bit_sel[4:3] == 2'(gi))
					nb[int_bit_sel[2:0]] = 1'b0;
				// set wins over a same-cycle clear
				if (cmd_valid && cmd.op == LPCAP_OP_SET_INT && in_int && rel_int == 8'(gi))
					nb = nb | cmd.data; // [RULE_03]
				if (gi == 0 && cat_prev_q != cat_byte)
					nb[0] = 1'b1; // capability change event [RULE_20] [RULE_13]
			end
			assign int_d[8*gi+:8] = nb;
		end
		for (gi = 0; gi < STAT_COUNT; gi++) begin : g_stat
			assign stat_d[8*gi+:8] = (cmd_valid && cmd.op == LPCAP_OP_WRITE_STAT && in_stat
				&& rel_stat == 8'(gi)) ? cmd.data : stat_q[8*gi+:8]; // [RULE_04]
		end
		for (gi = 0; gi < SCR_COUNT; gi++) begin : g_scr
			assign scr_d[8*gi+:8] = (cmd_valid && cmd.op == LPCAP_OP_WRITE_BURST && in_scr
				&& rel_scr == 8'(gi)) ? cmd.data : scr_q[8*gi+:8]; // [RULE_05] [RULE_16]
		end
	endgenerate

	// capability bytes have no storage, so writes cannot reach them
	assign cat_prev_d = cat_byte; // [RULE_02]

	// ***********************************
	// answer
	// ***********************************
	lpcap_rsp_s rsp_q;
	lpcap_rsp_s rsp_d;
	logic rsp_valid_q;
	logic rsp_valid_d;

	// read returns capability byte, other misses flag an error
	always_comb begin
		rsp_valid_d = cmd_valid;
		rsp_d.data = RESET_BYTE;
		rsp_d.error = 1'b0;
		if (cmd_valid) begin
			unique case (cmd.op)
				LPCAP_OP_READ_CAP: begin
					rsp_d.data = in_cap ? cap_byte : RESET_BYTE; // [RULE_01]
					rsp_d.error = !in_cap;
				end
				LPCAP_OP_SET_INT: rsp_d.error = !in_int; // [RULE_06]
				LPCAP_OP_WRITE_STAT: rsp_d.error = !in_stat; // [RULE_06]
				LPCAP_OP_WRITE_BURST: rsp_d.error = !in_scr; // [RULE_02] [RULE_06]
			endcase
		end
	end

	// all state registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			int_q <= '0;
			stat_q <= '0;
			scr_q <= '0;
			cat_prev_q <= RESET_BYTE;
			rsp_q <= '0;
			rsp_valid_q <= 1'b0;
		end else begin
			int_q <= int_d;
			stat_q <= stat_d;
			scr_q <= scr_d;
			cat_prev_q <= cat_prev_d;
			rsp_q <= rsp_d;
			rsp_valid_q <= rsp_valid_d;
		end
	end

	assign rsp = rsp_q;
	assign rsp_valid = rsp_valid_q;
	assign int_regs = int_q;
	assign stat_regs = stat_q;
	assign scr_regs = scr_q;
	assign cap_changed = int_q[0];

endmodule

// File: test/lpcap_regs_properties.sv
`timescale 1ns/1ps
module lpcap_regs_chk
	import lpcap_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire lpcap_cmd_s cmd,
	input wire lpcap_rsp_s rsp,
	input wire logic rsp_valid,
	input wire lpcap_cat_s category,
	input wire logic cap_changed
);
	// ***********************************
	// sideband answer and change flag properties
	// ***********************************
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// capability read strobe
	logic rd;
	assign rd = cmd_valid && cmd.op == LPCAP_OP_READ_CAP;
	property p_ans; cmd_valid |=> rsp_valid; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_ver; rd && cmd.offset == 8'h01 |=> rsp.data == 8'h20 && !rsp.error; endproperty
	a_ver: assert property (p_ver) else $error("bad version");
	property p_ro; cmd_valid && !rd && cmd.offset <= CAP_LAST |=> rsp.error; endproperty
	a_ro: assert property (p_ro) else $error("cap write taken");
	property p_rsvd; cmd_valid && cmd.offset > SCR_LAST |=> rsp.error; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved taken");
	property p_type; rd && cmd.offset == 8'h02 |=> rsp.data[3:0] != 4'h0 && !rsp.data[7]; endproperty
	a_type: assert property (p_type) else $error("bad type");
	property p_pow; rd && cmd.offset == 8'h02 |=> rsp.data[4] == $past(category.power); endproperty
	a_pow: assert property (p_pow) else $error("bad power bit");
	property p_plim; rd && cmd.offset == 8'h02 && !category.power |=> rsp.data[6:5] == 2'h0;
	endproperty
	a_plim: assert property (p_plim) else $error("limit kept");
	property p_cnt; rd && cmd.offset == 8'h0e |=> rsp.data == 8'h44; endproperty
	a_cnt: assert property (p_cnt) else $error("bad counts");
	property p_chg; $past(rst_n) && (category.power != $past(category.power)
		|| (category.power && category.plim != $past(category.plim))) |=> cap_changed;
	endproperty
	a_chg: assert property (p_chg) else $error("change not flagged");
	c_err: cover property (rsp_valid && rsp.error);
	c_chg: cover property (cap_changed);
	c_cnt: cover property (rd && cmd.offset == 8'h0e);
endmodule
bind lpcap_regs lpcap_regs_chk u_chk (.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid),
	.cmd(cmd), .rsp(rsp), .rsp_valid(rsp_valid), .category(category), .cap_changed(cap_changed));

// File: test/lpcap_peer_model.sv
`timescale 1ns/1ps
module lpcap_peer_model
	import lpcap_pkg::*;
(
	input wire logic clock,
	input wire logic rsp_valid,
	input wire lpcap_rsp_s rsp,
	output logic cmd_valid,
	output lpcap_cmd_s cmd
);
	// idle at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end
	// one byte per command, op picks region, released fields inverted
	task automatic send(input lpcap_op_e op, input logic [7:0] ofs, d, output lpcap_rsp_s r,
		output logic ok);
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd <= '{op, ofs, d};
		@(posedge clock);
		cmd_valid <= 1'b0;
		cmd <= ~cmd;
		#1;
		r = rsp;
		ok = rsp_valid;
	endtask
endmodule

// File: test/test_lpcap_regs.sv
`timescale 1ns/1ps
module test_lpcap_regs import lpcap_pkg::*;;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_valid, rsp_valid, ok, cap_changed;
	lpcap_cmd_s cmd;
	lpcap_rsp_s rsp, r;
	lpcap_cat_s category = '{4'h1, 1'b1, 2'h1};
	logic [47:0] lv = '1;
	logic [4:0] sel = '0;
	logic clr = 1'b0;
	logic [31:0] int_regs, stat_regs;
	logic [127:0] scr_regs;
	int fail_count = 0, compares = 0, cycles = 0;
	// ***********************************
	// clock, design and peer
	// ***********************************
	always #20 clock = ~clock;
	lpcap_regs #(.MAKER_ID(16'h0005), .PRODUCT_ID(16'h1234)) DUT (.clock(clock), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp), .rsp_valid(rsp_valid), .category(category),
		.video_link_modes(lv[7:0]), .audio_link_modes(lv[15:8]), .video_content_types(lv[23:16]),
		.logical_function_map(lv[31:24]), .link_clock_limit(lv[39:32]),
		.optional_feature_flags(lv[47:40]), .int_bit_sel(sel), .int_bit_clear(clr),
		.int_regs(int_regs), .stat_regs(stat_regs), .scr_regs(scr_regs), .cap_changed(cap_changed));
	lpcap_peer_model peer (.clock(clock), .rsp_valid(rsp_valid), .rsp(rsp), .cmd_valid(cmd_valid),
		.cmd(cmd));
	// compare and count
	task automatic check(input string n, input logic [127:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", n, exp, seen);
		end
	endtask
	// one command and its answer
	task automatic xf(input lpcap_op_e op, input logic [7:0] ofs, d, ex, input logic er);
		peer.send(op, ofs, d, r, ok);
		check("valid", ok, 1'b1);
		check("error", r.error, er);
		if (op == LPCAP_OP_READ_CAP && !er) check("data", r.data, ex);
	endtask
	// local clear of one interrupt bit
	task automatic clear(input logic [4:0] s);
		@(posedge clock);
		sel <= s;
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		#1;
	endtask
	// expected capability byte
	function automatic logic [7:0] cap(input logic [3:0] o);
		case (o)
			4'h1: cap = 8'h20;
			4'h2: cap = {1'b0, (category.power ? category.plim : 2'h0), category.power,
				(category.dev_type == 4'h0 ? 4'h1 : category.dev_type)};
			4'h5: cap = lv[7:0] & 8'h0f;
			4'h6: cap = lv[15:8] & 8'h03;
			4'h7: cap = lv[23:16] & 8'h8f;
			4'h8: cap = lv[31:24];
			4'h9: cap = lv[39:32];
			4'ha: cap = lv[47:40];
			4'hb: cap = 8'h12;
			4'hc: cap = 8'h34;
			4'hd: cap = 8'h10;
			4'he: cap = 8'h44;
			default: cap = 8'h00;
		endcase
	endfunction
	// ***********************************
	// scenarios
	// ***********************************
	task automatic t_caps();
		for (int p = 0; p < 2; p++) begin
			@(posedge clock);
			lv <= p ? 48'h5a5a_5a5a_5a5a : '1;
			#1;
			for (int o = 0; o < 16; o++)
				xf(LPCAP_OP_READ_CAP, 8'(o), 8'h00, cap(4'(o)), 1'b0);
		end
		$display("t_caps done");
	endtask
	task automatic t_regions();
		for (int k = 1; k < 4; k++)
			xf(lpcap_op_e'(k), 8'h02, 8'hff, 8'h00, 1'b1);
		xf(LPCAP_OP_READ_CAP, 8'h02, 8'h00, cap(4'h2), 1'b0);
		xf(LPCAP_OP_READ_CAP, 8'h10, 8'h00, 8'h00, 1'b1);
		xf(LPCAP_OP_WRITE_BURST, 8'h80, 8'h11, 8'h00, 1'b1);
		xf(LPCAP_OP_SET_INT, 8'h21, 8'h04, 8'h00, 1'b0);
		xf(LPCAP_OP_SET_INT, 8'h21, 8'h01, 8'h00, 1'b0);
		xf(LPCAP_OP_SET_INT, 8'h24, 8'h01, 8'h00, 1'b1);
		xf(LPCAP_OP_WRITE_STAT, 8'h21, 8'h01, 8'h00, 1'b1);
		check("int1", int_regs[15:8], 8'h05);
		clear(5'h0a);
		check("int1 clr", int_regs[15:8], 8'h01);
		xf(LPCAP_OP_WRITE_STAT, 8'h31, 8'h55, 8'h00, 1'b0);
		xf(LPCAP_OP_WRITE_STAT, 8'h31, 8'h0a, 8'h00, 1'b0);
		check("stat1", stat_regs[15:8], 8'h0a);
		xf(LPCAP_OP_WRITE_BURST, 8'h40, 8'haa, 8'h00, 1'b0);
		xf(LPCAP_OP_WRITE_BURST, 8'h4f, 8'h5b, 8'h00, 1'b0);
		xf(LPCAP_OP_WRITE_BURST, 8'h50, 8'h5b, 8'h00, 1'b1);
		check("scr", {scr_regs[127:120], scr_regs[7:0]}, 16'h5baa);
		$display("t_regions done");
	endtask
	task automatic t_cat();
		logic [7:0] prev;
		for (int c = 0; c < 32; c++) begin
			prev = cap(4'h2);
			@(posedge clock);
			category <= '{4'(c[4:3]), c[2], 2'(c[1:0])};
			#1;
			xf(LPCAP_OP_READ_CAP, 8'h02, 8'h00, cap(4'h2), 1'b0);
			check("changed", cap_changed, cap(4'h2) != prev);
			clear(5'h00);
			check("cleared", cap_changed, 1'b0);
		end
		$display("t_cat done");
	endtask
	// verdict
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		check("announce", cap_changed, 1'b1);
		check("stat rst", stat_regs, 32'h0);
		t_caps();
		t_regions();
		t_cat();
		tally_and_finish();
	end
endmodule
